/* File: core/lmc_defs.vh */
// How it works
// - reversal compensation acts only in position or positioning mode
// - a reversal of commanded travel direction fires one compensation event
// - compensation type field: 0 turns reversal compensation off, 1 on
// - dead band counts single pulses for unit 0, thousand pulses for unit 1
// - separate amounts for forward-to-reverse and reverse-to-forward reversals
// - each compensation starts after the programmed start delay
// - start delay resets to zero, so compensation starts at once
// - droop fluctuation within dead band means zero speed, no reversal seen
// - nonzero time constant high-pass filters the amount; zero bypasses filter
// - trace compensation needs the trace selection field equal to 2
// - trace compensation cancels residual droop at steady speed and ramps
// - in-position condition 1 also requires command output complete
// - trace compensation acts only in position or positioning mode
// - trace compensation is blocked while model control selection is 2
`ifndef LMC_DEFS_VH
`define LMC_DEFS_VH

// register byte addresses
`define LMC_A_CTRL 8'h00
`define LMC_A_AMT_F2R 8'h04
`define LMC_A_AMT_R2F 8'h08
`define LMC_A_HP_TC 8'h0C
`define LMC_A_DELAY 8'h10
`define LMC_A_DEAD_BAND 8'h14
`define LMC_A_TRACE_GAIN 8'h18
`define LMC_A_STATUS 8'h1C
`define LMC_A_TORQUE 8'h20

// control register field positions
`define LMC_F_TYPE 0
`define LMC_F_DB_UNIT 1
`define LMC_F_INPOS 2
`define LMC_F_TRACE_LO 4
`define LMC_F_GAIN_LO 8
`define LMC_F_MBC_LO 12

// field encodings
`define LMC_TYPE_ON 1'b1
`define LMC_DB_KPULSE 1'b1
`define LMC_DB_KSCALE 32'h0000_03E8
`define LMC_TRACE_ON 2'h2
`define LMC_MBC_PID 2'h2
`define LMC_INPOS_DONE 1'b1
`define LMC_MODE_POS 2'h0
`define LMC_MODE_PTP 2'h1

// reset values
`define LMC_RST_DELAY 16'h0000
`define LMC_RST_HP_TC 16'h0000
`define LMC_RST_GAIN_MODE 2'h0
`define LMC_RST_TRACE_GAIN 16'h0100

// timing: delay and filter settings count 0.1 ms steps
`define LMC_CLK_NS 10
`define LMC_STEP_NS 100000
`define LMC_STEP_CYCLES (`LMC_STEP_NS / `LMC_CLK_NS)

`endif

/* File: core/lost_motion_comp.v */
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.vh"

module lost_motion_comp
#(
	parameter STEP_CYCLES = `LMC_STEP_CYCLES
)
(
	// clock and reset
	input wire sys_clk,
	input wire arst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// position loop inputs
	input wire [1:0] ctrl_mode,
	input wire signed [15:0] cmd_speed,
	input wire signed [31:0] droop,
	input wire signed [15:0] torque_cmd_in,
	input wire in_range,
	input wire cmd_output_done,
	// outputs to current loop and i/o
	output reg signed [15:0] torque_cmd_out,
	output reg in_position_flag,
	output reg comp_active
);

	// last count of the step timer, cut to the 16-bit counter on purpose
	localparam [31:0] STEP_FULL = STEP_CYCLES - 1;
	localparam [15:0] STEP_LAST = STEP_FULL[15:0];

	reg rst_s1;
	reg rst_n;
	reg reversal_comp_select;
	reg db_unit;
	reg in_position_condition;
	reg [1:0] trace_comp_select;
	reg [1:0] gain_tuning_mode;
	reg [1:0] model_based_control_select;
	reg signed [15:0] comp_amount_fwd_to_rev;
	reg signed [15:0] comp_amount_rev_to_fwd;
	reg [15:0] comp_highpass_time_constant;
	reg [15:0] comp_start_delay;
	reg [15:0] comp_dead_band;
	reg [15:0] model_loop_gain;
	reg [15:0] step_cnt;
	reg step;
	reg signed [31:0] droop_prev;
	reg have_dir;
	reg last_dir;
	reg comp_pending;
	reg [15:0] delay_cnt;
	reg signed [15:0] pend_amt;
	reg signed [23:0] comp_acc;
	reg [31:0] next_rdata;

	wire pos_ok;
	wire lmc_en;
	wire trace_on;
	wire [31:0] db_pulses;
	wire signed [31:0] fluct;
	wire [31:0] fluct_abs;
	wire zero_speed;
	wire moving;
	wire new_dir;
	wire reversal;
	wire signed [15:0] sel_amt;
	wire signed [23:0] decay;
	wire signed [23:0] decay_q;
	wire signed [48:0] trace_prod;
	wire signed [49:0] trace_term;
	wire signed [49:0] torque_sum;
	wire signed [15:0] next_torque;

	// reset release through two flops
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// mode qualifiers
	assign pos_ok = (ctrl_mode == `LMC_MODE_POS) || (ctrl_mode == `LMC_MODE_PTP);
	assign lmc_en = pos_ok && (reversal_comp_select == `LMC_TYPE_ON);
	assign trace_on = pos_ok
		&& (trace_comp_select == `LMC_TRACE_ON)
		&& (model_based_control_select != `LMC_MBC_PID);

	// dead band scaled by its unit, compared with droop change per step
	assign db_pulses = (db_unit == `LMC_DB_KPULSE) ?
		({16'h0000, comp_dead_band} * `LMC_DB_KSCALE) : {16'h0000, comp_dead_band};
	assign fluct = droop - droop_prev;
	assign fluct_abs = fluct[31] ? (32'h0000_0000 - fluct) : fluct;
	assign zero_speed = (fluct_abs <= db_pulses);
	assign moving = (cmd_speed != 16'sh0000) && !zero_speed;
	// zero command counts as forward here but never as moving
	assign new_dir = !cmd_speed[15];

	// a reversal is judged once per step so the dead band sees a whole step of droop
	assign reversal = step && lmc_en && moving && have_dir && (new_dir != last_dir);
	// old direction forward means the axis now turns to reverse
	assign sel_amt = last_dir ? comp_amount_fwd_to_rev : comp_amount_rev_to_fwd;

	// first order decay: one time constant in steps drains about 63 percent
	assign decay_q = comp_acc / $signed({8'h00, comp_highpass_time_constant});
	// once the quotient truncates to zero the remainder goes in one step;
	// otherwise an amount of either sign below the time constant would park there and never release
	assign decay = (comp_highpass_time_constant == 16'h0000) ? 24'sh00_0000 :
		(decay_q == 24'sh00_0000) ? comp_acc : decay_q;

	// trace term: residual droop times gain, 8 fraction bits
	assign trace_prod = droop * $signed({1'b0, model_loop_gain});
	assign trace_term = trace_on ? {{9{trace_prod[48]}}, trace_prod[48:8]} : 50'sh0;
	assign torque_sum = {{34{torque_cmd_in[15]}}, torque_cmd_in}
		+ {{34{comp_acc[23]}}, comp_acc[23:8]} + trace_term;
	// saturate rather than wrap, a wrapped torque would flip its sign
	assign next_torque = (torque_sum > 50'sh0_0000_0000_7FFF) ? 16'sh7FFF :
		(torque_sum < -50'sh0_0000_0000_8000) ? 16'sh8000 : torque_sum[15:0];

	// register writes; gain tuning mode is only stored,
	// the order of set-up is left to software
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reversal_comp_select <= 1'b0;
			db_unit <= 1'b0;
			in_position_condition <= 1'b0;
			trace_comp_select <= 2'h0;
			gain_tuning_mode <= `LMC_RST_GAIN_MODE;
			model_based_control_select <= 2'h0;
			comp_amount_fwd_to_rev <= 16'sh0000;
			comp_amount_rev_to_fwd <= 16'sh0000;
			comp_highpass_time_constant <= `LMC_RST_HP_TC;
			comp_start_delay <= `LMC_RST_DELAY;
			comp_dead_band <= 16'h0000;
			model_loop_gain <= `LMC_RST_TRACE_GAIN;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`LMC_A_CTRL:
				begin
					reversal_comp_select <= reg_wdata[`LMC_F_TYPE];
					db_unit <= reg_wdata[`LMC_F_DB_UNIT];
					in_position_condition <= reg_wdata[`LMC_F_INPOS];
					trace_comp_select <= reg_wdata[`LMC_F_TRACE_LO +: 2];
					gain_tuning_mode <= reg_wdata[`LMC_F_GAIN_LO +: 2];
					model_based_control_select <= reg_wdata[`LMC_F_MBC_LO +: 2];
				end
				`LMC_A_AMT_F2R: comp_amount_fwd_to_rev <= reg_wdata[15:0];
				`LMC_A_AMT_R2F: comp_amount_rev_to_fwd <= reg_wdata[15:0];
				`LMC_A_HP_TC: comp_highpass_time_constant <= reg_wdata[15:0];
				`LMC_A_DELAY: comp_start_delay <= reg_wdata[15:0];
				`LMC_A_DEAD_BAND: comp_dead_band <= reg_wdata[15:0];
				`LMC_A_TRACE_GAIN: model_loop_gain <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// read mux, data only in the cycle after the strobe
	always @*
	begin
		next_rdata = 32'h0000_0000;
		case (reg_addr)
			`LMC_A_CTRL: next_rdata = {18'h0_0000, model_based_control_select, 2'h0,
				gain_tuning_mode, 2'h0, trace_comp_select, 1'b0, in_position_condition,
				db_unit, reversal_comp_select};
			`LMC_A_AMT_F2R: next_rdata = {{16{comp_amount_fwd_to_rev[15]}}, comp_amount_fwd_to_rev};
			`LMC_A_AMT_R2F: next_rdata = {{16{comp_amount_rev_to_fwd[15]}}, comp_amount_rev_to_fwd};
			`LMC_A_HP_TC: next_rdata = {16'h0000, comp_highpass_time_constant};
			`LMC_A_DELAY: next_rdata = {16'h0000, comp_start_delay};
			`LMC_A_DEAD_BAND: next_rdata = {16'h0000, comp_dead_band};
			`LMC_A_TRACE_GAIN: next_rdata = {16'h0000, model_loop_gain};
			`LMC_A_STATUS: next_rdata = {26'h000_0000, trace_on, comp_pending, comp_active,
				last_dir, have_dir, in_position_flag};
			`LMC_A_TORQUE: next_rdata = {{16{torque_cmd_out[15]}}, torque_cmd_out};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// idle read data is zero, so a stale word never looks like an answer
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
	end

	// 0.1 ms step timer for delay, filter and droop sampling
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			step_cnt <= 16'h0000;
			step <= 1'b0;
		end
		else
		begin
			step <= (step_cnt == STEP_LAST);
			step_cnt <= (step_cnt == STEP_LAST) ? 16'h0000 : step_cnt + 16'h0001;
		end
	end

	// direction tracking and compensation sequencing
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			droop_prev <= 32'sh0000_0000;
			have_dir <= 1'b0;
			last_dir <= 1'b0;
			comp_pending <= 1'b0;
			delay_cnt <= 16'h0000;
			pend_amt <= 16'sh0000;
			comp_acc <= 24'sh00_0000;
			comp_active <= 1'b0;
		end
		else if (!lmc_en)
		begin
			// leaving position mode or disabling drops any compensation at once
			have_dir <= 1'b0;
			comp_pending <= 1'b0;
			comp_acc <= 24'sh00_0000;
			comp_active <= 1'b0;
			droop_prev <= droop;
		end
		else if (step)
		begin
			droop_prev <= droop;
			// zero speed steps keep the old direction, so jitter in the dead band fires nothing
			if (moving)
			begin
				have_dir <= 1'b1;
				last_dir <= new_dir;
			end
			if (reversal && (comp_start_delay == 16'h0000))
			begin
				// zero delay: apply on the reversal step itself
				comp_pending <= 1'b0;
				comp_acc <= {sel_amt, 8'h00};
				comp_active <= 1'b1;
			end
			else if (reversal)
			begin
				// a new reversal restarts the delay with the new amount
				comp_pending <= 1'b1;
				delay_cnt <= comp_start_delay - 16'h0001;
				pend_amt <= sel_amt;
				comp_acc <= comp_acc - decay;
			end
			else if (comp_pending && (delay_cnt == 16'h0000))
			begin
				comp_pending <= 1'b0;
				comp_acc <= {pend_amt, 8'h00};
				comp_active <= 1'b1;
			end
			else
			begin
				if (comp_pending)
					delay_cnt <= delay_cnt - 16'h0001;
				comp_acc <= comp_acc - decay;
				// drop the busy flag on the step that drains the last lsb
				if (comp_active && (comp_acc - decay == 24'sh00_0000))
					comp_active <= 1'b0;
			end
		end
	end

	// torque output and in-position flag
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			torque_cmd_out <= 16'sh0000;
			in_position_flag <= 1'b0;
		end
		else
		begin
			torque_cmd_out <= next_torque;
			// with trace on droop stays near zero, so range alone says little
			if (in_position_condition == `LMC_INPOS_DONE)
				in_position_flag <= in_range && cmd_output_done;
			else
				in_position_flag <= in_range;
		end
	end

endmodule
`default_nettype wire

/* File: test/lost_motion_comp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.vh"
module lmc_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// loop side
	input wire logic [1:0] ctrl_mode,
	input wire logic signed [15:0] torque_cmd_in,
	input wire logic in_range,
	input wire logic cmd_output_done,
	input wire logic signed [15:0] torque_cmd_out,
	input wire logic in_position_flag,
	input wire logic comp_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// compensation lives only in the two position modes
	chk_mode_clear: assert property (comp_active && ctrl_mode[1] |-> ##[1:2] !comp_active)
		else $error("compensation kept outside position modes");
	chk_mode_rise: assert property ($rose(comp_active) |-> !$past(ctrl_mode[1]))
		else $error("compensation started outside position modes");
	// other modes pass the torque through untouched, trace term included
	chk_pass_through: assert property (ctrl_mode[1] [*3] |-> torque_cmd_out == $past(torque_cmd_in))
		else $error("torque altered outside position modes");
	chk_inpos_range: assert property (!in_range |=> !in_position_flag)
		else $error("in-position flag set out of range");
	chk_inpos_both: assert property (in_range && cmd_output_done |=> in_position_flag)
		else $error("in-position flag missing");
	// read data stands one cycle only
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	chk_torque_read: assert property (reg_rd && reg_addr == `LMC_A_TORQUE |=> reg_rdata[15:0] == $past(torque_cmd_out))
		else $error("torque readback differs from output");
	chk_status_read: assert property (reg_rd && reg_addr == `LMC_A_STATUS |=> reg_rdata[0] == $past(in_position_flag))
		else $error("status in-position bit differs");
	cov_reversal: cover property ($rose(comp_active));
	cov_inpos: cover property ($rose(in_position_flag));
	cov_mode_off: cover property (comp_active ##1 ctrl_mode[1]);
endmodule
bind lost_motion_comp lmc_monitor mon (.sys_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .ctrl_mode,
	.torque_cmd_in, .in_range, .cmd_output_done, .torque_cmd_out, .in_position_flag, .comp_active);
`default_nettype wire

/* File: test/servo_axis_model.sv */
`timescale 1ns/1ps
`default_nettype none
module servo_axis_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// commanded speed in, position error out
	input wire logic signed [15:0] cmd_speed,
	output var logic signed [31:0] droop
);
	// axis lags its command, so the error integrates speed
	always @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			droop <= 32'sh0000_0000;
		else
			droop <= droop + cmd_speed;
endmodule
`default_nettype wire

/* File: test/test_lost_motion_comp.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.vh"
module test_lost_motion_comp;
	logic sys_clk, arst_n, reg_wr, reg_rd, in_range, cmd_output_done, in_position_flag, comp_active;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [1:0] ctrl_mode;
	logic signed [15:0] cmd_speed, torque_cmd_in, torque_cmd_out, tin, f2r, r2f, sp, g;
	logic signed [31:0] droop;
	integer seed, bad_count, num_checks, n, i;
	lost_motion_comp #(.STEP_CYCLES(4)) DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ctrl_mode, .cmd_speed, .droop, .torque_cmd_in, .in_range, .cmd_output_done,
		.torque_cmd_out, .in_position_flag, .comp_active);
	servo_axis_model axis (.sys_clk, .arst_n, .cmd_speed, .droop);
	// 100 MHz
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic signed [15:0] sat(input logic signed [63:0] v);
		sat = v > 64'sh7fff ? 16'sh7fff : v < -64'sh8000 ? 16'sh8000 : v[15:0];
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input integer c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// new speed, then bounded wait for the torque to reach the expected value
	task automatic rev(input logic signed [15:0] s, input logic signed [15:0] exp);
		@(posedge sys_clk);
		cmd_speed <= s;
		#1;
		n = 0;
		while (torque_cmd_out !== exp && n < 80)
		begin
			@(posedge sys_clk);
			#1 n = n + 1;
		end
		check("torque", torque_cmd_out, exp);
		if (n >= 80)
			finish_test();
	endtask
	initial
	begin
		seed = 32'h0000_26a4;
		{bad_count, num_checks} = 0;
		{arst_n, reg_wr, reg_rd, in_range, cmd_output_done} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		ctrl_mode = `LMC_MODE_POS;
		cmd_speed = 16'sh0000;
		tin = $random(seed) % 500;
		f2r = 1 + {$random(seed)} % 200;
		r2f = -1 - {$random(seed)} % 200;
		sp = 1 + {$random(seed)} % 100;
		g = 1 + {$random(seed)} % 255;
		torque_cmd_in = tin;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(`LMC_A_DELAY);
		check("delay", d, 32'h0000_0000);
		rd(`LMC_A_TRACE_GAIN);
		check("gain", d, 32'h0000_0100);
		rd(8'h24);
		check("hole", d, 32'h0000_0000);
		wr(`LMC_A_AMT_F2R, {16'h0000, f2r});
		wr(`LMC_A_AMT_R2F, {16'h0000, r2f});
		rd(`LMC_A_AMT_R2F);
		check("amount", d, {{16{r2f[15]}}, r2f});
		wr(`LMC_A_CTRL, 32'h0000_0001);
		rev(sp, tin);
		cyc(16);
		check("idle", torque_cmd_out, tin);
		rev(-sp, tin + f2r);
		check("fast", n <= 10, 1);
		rev(sp, tin + r2f);
		wr(`LMC_A_CTRL, 32'h0000_0003);
		wr(`LMC_A_DEAD_BAND, 32'h0000_0001);
		rev(-sp, tin + r2f);
		cyc(40);
		check("dead band", torque_cmd_out, tin + r2f);
		wr(`LMC_A_CTRL, 32'h0000_0001);
		rev(-sp, tin + f2r);
		wr(`LMC_A_DELAY, 32'h0000_0003);
		rev(sp, tin + r2f);
		check("late", n >= 12, 1);
		wr(`LMC_A_DELAY, 32'h0000_0000);
		$display("reversal tests done");
		ctrl_mode <= 2'h2;
		cyc(4);
		check("off mode", {comp_active, torque_cmd_out}, {1'b0, tin});
		wr(`LMC_A_HP_TC, 32'h0000_0002);
		ctrl_mode <= `LMC_MODE_PTP;
		cyc(16);
		rev(-sp, tin + f2r);
		cyc(100);
		check("decay", torque_cmd_out, tin);
		wr(`LMC_A_HP_TC, 32'h0000_0000);
		rev(sp, tin + r2f);
		wr(`LMC_A_CTRL, 32'h0000_0000);
		cyc(3);
		check("type off", torque_cmd_out, tin);
		$display("mode and filter tests done");
		cmd_speed <= 16'sh0000;
		wr(`LMC_A_CTRL, 32'h0000_0300);
		wr(`LMC_A_TRACE_GAIN, {16'h0000, g});
		wr(`LMC_A_CTRL, 32'h0000_0320);
		cyc(3);
		check("trace", torque_cmd_out, sat(tin + ((droop * g) >>> 8)));
		wr(`LMC_A_CTRL, 32'h0000_2320);
		cyc(3);
		check("pid", torque_cmd_out, tin);
		wr(`LMC_A_CTRL, 32'h0000_0320);
		ctrl_mode <= 2'h3;
		cyc(3);
		check("trace mode", torque_cmd_out, tin);
		ctrl_mode <= `LMC_MODE_POS;
		$display("trace tests done");
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(`LMC_A_CTRL, i[2] ? 32'h0000_0004 : 32'h0000_0000);
			{in_range, cmd_output_done} <= i[1:0];
			cyc(2);
			check("in position", in_position_flag, i[1] & (i[0] | !i[2]));
			rd(`LMC_A_STATUS);
			check("status", {d[5:3], d[1:0]}, {4'h0, i[1] & (i[0] | !i[2])});
		end
		rd(`LMC_A_TORQUE);
		check("torque read", d[15:0], tin);
		$display("in-position tests done");
		finish_test();
	end
endmodule
`default_nettype wire
